//--- src/tw_timer8.sv
// 8-bit timer with two compare channels, waveform control and an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module tw_timer8 #(
	parameter int ADDR_W = 8
) (
	input wire logic I_CLK_SYS,
	input wire logic I_RESET_N,
	input wire logic I_CLK_EN,
	input wire logic I_TIMER_TICK,
	input wire logic I_PORT_DATA_A,
	input wire logic I_PORT_DATA_B,
	input wire logic [ADDR_W-1:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [ADDR_W-1:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output var tw_pkg::tw_pin_t O_PIN_A,
	output var tw_pkg::tw_pin_t O_PIN_B,
	output var tw_pkg::tw_flags_t O_FLAGS
);
	// the decoder compares the full address, so it must at least hold the offsets
	if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
		$error("ADDR_W must lie between 8 and 32");
	end

	logic [7:0] ctrl_a_reg;
	logic mode_high_reg;
	logic [7:0] cnt_reg, cnt_next;
	logic dir_up_reg, dir_up_next;
	logic block_reg;
	logic [7:0] buf_a_reg, buf_b_reg, act_a_reg, act_b_reg;
	tw_pkg::tw_flags_t flags_reg, flags_next;
	logic [1:0] dir_reg;
	logic wave_a_reg, wave_a_next, wave_b_reg, wave_b_next;
	logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg, rdata_reg;
	logic wstrb_reg;
	logic [1:0] bresp_reg, rresp_reg;

	// mode decode, TOP source and the effective compare values
	wire tw_pkg::tw_mode_t mode = tw_pkg::tw_mode_t'({mode_high_reg, ctrl_a_reg[1:0]}); // R12
	wire [1:0] com_a = ctrl_a_reg[tw_pkg::TW_BIT_COM_A +: 2];
	wire [1:0] com_b = ctrl_a_reg[tw_pkg::TW_BIT_COM_B +: 2];
	wire is_pc = (mode == tw_pkg::TW_MODE_PC_FF) || (mode == tw_pkg::TW_MODE_PC_CMP);
	wire is_fast = (mode == tw_pkg::TW_MODE_FAST_FF) || (mode == tw_pkg::TW_MODE_FAST_CMP);
	wire non_pwm = !is_pc && !is_fast;
	// reserved modes 4 and 6 fall back to plain counting so the logic stays defined
	wire top_is_cmp = (mode == tw_pkg::TW_MODE_CLR_MATCH) || (mode == tw_pkg::TW_MODE_PC_CMP) ||
		(mode == tw_pkg::TW_MODE_FAST_CMP); // R13 R14 R15
	wire clear_on_top = (mode == tw_pkg::TW_MODE_CLR_MATCH) || is_fast; // R17
	// non-PWM compares see software writes at once, PWM modes use the buffered copy
	wire [7:0] ocr_a = non_pwm ? buf_a_reg : act_a_reg; // R13
	wire [7:0] ocr_b = non_pwm ? buf_b_reg : act_b_reg;
	wire [7:0] top = top_is_cmp ? ocr_a : tw_pkg::TW_MAX;

	// timer events, all but the non-PWM buffer update qualified by the tick acting as a clock enable
	wire tick = I_CLK_EN && I_TIMER_TICK; // R01
	wire at_top = cnt_reg == top;
	wire at_bottom = cnt_reg == tw_pkg::TW_BOTTOM;
	wire match_a = tick && !block_reg && cnt_reg == ocr_a;
	wire match_b = tick && !block_reg && cnt_reg == ocr_b;
	wire wrap = tick && is_fast && at_top; // R18
	wire pc_top = tick && is_pc && at_top && dir_up_reg;
	wire buf_update = non_pwm || pc_top || wrap; // R14 R15
	wire ovf_set = is_pc ? (tick && at_bottom && !dir_up_reg) : // R14
		(mode == tw_pkg::TW_MODE_FAST_CMP) ? (tick && at_top) : // R15
		(tick && cnt_reg == tw_pkg::TW_MAX); // R13

	// register write decode
	wire wr_go = I_CLK_EN && aw_hold_reg && w_hold_reg && !bvalid_reg;
	wire wr_en = wr_go && wstrb_reg;
	wire [7:0] wbyte = wdata_reg[7:0];
	wire wr_ctrl_a = wr_en && awaddr_reg == ADDR_W'(tw_pkg::TW_OFS_WAVE_CTRL_A);
	wire wr_ctrl_b = wr_en && awaddr_reg == ADDR_W'(tw_pkg::TW_OFS_TIMER_CTRL_B);
	wire wr_cnt = wr_en && awaddr_reg == ADDR_W'(tw_pkg::TW_OFS_COUNTER);
	wire wr_cmp_a = wr_en && awaddr_reg == ADDR_W'(tw_pkg::TW_OFS_COMPARE_A);
	wire wr_cmp_b = wr_en && awaddr_reg == ADDR_W'(tw_pkg::TW_OFS_COMPARE_B);
	wire wr_flags = wr_en && awaddr_reg == ADDR_W'(tw_pkg::TW_OFS_FLAGS);
	wire wr_dir = wr_en && awaddr_reg == ADDR_W'(tw_pkg::TW_OFS_PORT_DIR);

	// compare output action for one channel in the current waveform mode
	function automatic logic f_wave_next(input logic cur, input logic [1:0] com, input logic hit,
		input logic bottom_hit, input logic top_hit, input logic ocr_top, input logic tog_ok,
		input logic fast, input logic pc, input logic up);
		logic nxt;
		nxt = cur;
		if (!fast && !pc) begin
			if (hit && com == tw_pkg::TW_COM_TOGGLE) begin
				nxt = !cur;
			end else if (hit && com[1]) begin
				nxt = com[0];
			end
		end else if (com == tw_pkg::TW_COM_TOGGLE) begin
			if (hit && tog_ok) begin
				nxt = !cur;
			end
		end else if (com[1] && fast) begin
			if (hit && !ocr_top) begin
				nxt = com[0];
			end
			if (bottom_hit) begin
				nxt = !com[0];
			end
		end else if (com[1]) begin
			if (hit && !ocr_top) begin
				nxt = up ? com[0] : !com[0];
			end
			if (top_hit && ocr_top) begin
				nxt = !com[0];
			end
		end
		return nxt;
	endfunction

	// channel A may toggle in PWM modes only with the high mode bit, channel B never
	assign wave_a_next = f_wave_next(wave_a_reg, com_a, match_a, wrap && !wr_cnt, tick && at_top && dir_up_reg,
		ocr_a == top, mode_high_reg, is_fast, is_pc, dir_up_reg); // R03 R04 R05 R06 R07
	assign wave_b_next = f_wave_next(wave_b_reg, com_b, match_b, wrap && !wr_cnt, tick && at_top && dir_up_reg,
		ocr_b == top, 1'b0, is_fast, is_pc, dir_up_reg); // R08 R09 R10

	// counter sequence; a top of zero in phase mode simply parks the counter
	always_comb begin
		cnt_next = cnt_reg;
		dir_up_next = dir_up_reg;
		if (wr_cnt) begin
			cnt_next = wbyte;
		end else if (tick && is_pc) begin
			if (dir_up_reg && at_top) begin
				cnt_next = (top == tw_pkg::TW_BOTTOM) ? tw_pkg::TW_BOTTOM : cnt_reg - 8'h01; // R19
				dir_up_next = 1'b0;
			end else if (!dir_up_reg && at_bottom) begin
				cnt_next = (top == tw_pkg::TW_BOTTOM) ? tw_pkg::TW_BOTTOM : cnt_reg + 8'h01;
				dir_up_next = 1'b1;
			end else begin
				cnt_next = dir_up_reg ? cnt_reg + 8'h01 : cnt_reg - 8'h01;
			end
		end else if (tick) begin
			cnt_next = (clear_on_top && at_top) ? tw_pkg::TW_BOTTOM : cnt_reg + 8'h01; // R17
			dir_up_next = 1'b1;
		end
	end

	// sticky flags: a hardware set in the same cycle as a write-one clear wins
	assign flags_next = (flags_reg & ~(wr_flags ? wbyte[2:0] : 3'h0)) | {match_b, match_a, ovf_set}; // R17

	// timer state, frozen while the clock enable is low
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			ctrl_a_reg <= tw_pkg::TW_RST_WAVE_CTRL_A; // R20
			mode_high_reg <= tw_pkg::TW_RST_MODE_HIGH;
			cnt_reg <= tw_pkg::TW_RST_COUNTER;
			dir_up_reg <= 1'b1;
			block_reg <= 1'b0;
			buf_a_reg <= tw_pkg::TW_RST_COMPARE;
			buf_b_reg <= tw_pkg::TW_RST_COMPARE;
			act_a_reg <= tw_pkg::TW_RST_COMPARE;
			act_b_reg <= tw_pkg::TW_RST_COMPARE;
			flags_reg <= tw_pkg::TW_RST_FLAGS;
			dir_reg <= tw_pkg::TW_RST_PORT_DIR;
			wave_a_reg <= 1'b0;
			wave_b_reg <= 1'b0;
		end else if (I_CLK_EN) begin // R01
			ctrl_a_reg <= wr_ctrl_a ? (wbyte & tw_pkg::TW_WAVE_CTRL_A_WMASK) : ctrl_a_reg; // R11
			mode_high_reg <= wr_ctrl_b ? wbyte[tw_pkg::TW_BIT_MODE_HIGH] : mode_high_reg; // R12
			cnt_reg <= cnt_next;
			dir_up_reg <= dir_up_next;
			block_reg <= wr_cnt || (block_reg && !tick);
			buf_a_reg <= wr_cmp_a ? wbyte : buf_a_reg;
			buf_b_reg <= wr_cmp_b ? wbyte : buf_b_reg;
			act_a_reg <= buf_update ? buf_a_reg : act_a_reg;
			act_b_reg <= buf_update ? buf_b_reg : act_b_reg;
			flags_reg <= flags_next;
			dir_reg <= wr_dir ? wbyte[1:0] : dir_reg;
			wave_a_reg <= wave_a_next;
			wave_b_reg <= wave_b_next;
		end
	end

	// pin takeover: a nonzero mode field replaces the ordinary port value
	// in PWM modes channel A code 01 without the high mode bit hands the pin back to the port
	wire pin_a_conn = (com_a != tw_pkg::TW_COM_OFF) &&
		!(!non_pwm && com_a == tw_pkg::TW_COM_TOGGLE && !mode_high_reg); // R04
	assign O_PIN_A.level = pin_a_conn ? wave_a_reg : I_PORT_DATA_A; // R02
	assign O_PIN_A.oe_n = !dir_reg[0]; // R02
	assign O_PIN_B.level = (com_b != tw_pkg::TW_COM_OFF) ? wave_b_reg : I_PORT_DATA_B; // R08
	assign O_PIN_B.oe_n = !dir_reg[1];
	assign O_FLAGS = flags_reg;

	// bus handshakes; one write and one read in flight, all halted with the enable
	assign O_AWREADY = I_CLK_EN && !aw_hold_reg;
	assign O_WREADY = I_CLK_EN && !w_hold_reg;
	assign O_ARREADY = I_CLK_EN && !rvalid_reg;
	assign O_BVALID = bvalid_reg;
	assign O_BRESP = bresp_reg;
	assign O_RVALID = rvalid_reg;
	assign O_RDATA = rdata_reg;
	assign O_RRESP = rresp_reg;

	// address maps; misaligned or unknown words answer with a slave error
	wire w_mapped = wr_ctrl_a || wr_ctrl_b || wr_cnt || wr_cmp_a || wr_cmp_b || wr_flags || wr_dir ||
		(!wstrb_reg && (awaddr_reg == ADDR_W'(tw_pkg::TW_OFS_WAVE_CTRL_A) ||
		awaddr_reg == ADDR_W'(tw_pkg::TW_OFS_TIMER_CTRL_B) || awaddr_reg == ADDR_W'(tw_pkg::TW_OFS_COUNTER) ||
		awaddr_reg == ADDR_W'(tw_pkg::TW_OFS_COMPARE_A) || awaddr_reg == ADDR_W'(tw_pkg::TW_OFS_COMPARE_B) ||
		awaddr_reg == ADDR_W'(tw_pkg::TW_OFS_FLAGS) || awaddr_reg == ADDR_W'(tw_pkg::TW_OFS_PORT_DIR)));
	wire rd_ctrl_a = I_ARADDR == ADDR_W'(tw_pkg::TW_OFS_WAVE_CTRL_A);
	wire rd_ctrl_b = I_ARADDR == ADDR_W'(tw_pkg::TW_OFS_TIMER_CTRL_B);
	wire rd_cnt = I_ARADDR == ADDR_W'(tw_pkg::TW_OFS_COUNTER);
	wire rd_cmp_a = I_ARADDR == ADDR_W'(tw_pkg::TW_OFS_COMPARE_A);
	wire rd_cmp_b = I_ARADDR == ADDR_W'(tw_pkg::TW_OFS_COMPARE_B);
	wire rd_flags = I_ARADDR == ADDR_W'(tw_pkg::TW_OFS_FLAGS);
	wire rd_dir = I_ARADDR == ADDR_W'(tw_pkg::TW_OFS_PORT_DIR);
	wire rd_mapped = rd_ctrl_a || rd_ctrl_b || rd_cnt || rd_cmp_a || rd_cmp_b || rd_flags || rd_dir;
	// compare registers read back the software copy, not the active one
	wire [31:0] rd_word = ({32{rd_ctrl_a}} & {24'h0, ctrl_a_reg}) |
		({32{rd_ctrl_b}} & ({31'h0, mode_high_reg} << tw_pkg::TW_BIT_MODE_HIGH)) |
		({32{rd_cnt}} & {24'h0, cnt_reg}) | ({32{rd_cmp_a}} & {24'h0, buf_a_reg}) |
		({32{rd_cmp_b}} & {24'h0, buf_b_reg}) | ({32{rd_flags}} & {29'h0, flags_reg}) |
		({32{rd_dir}} & {30'h0, dir_reg});

	// write channel: address and data taken in either order, response after both
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 32'h0;
			wstrb_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= tw_pkg::TW_RESP_OKAY;
		end else if (I_CLK_EN) begin
			if (I_AWVALID && !aw_hold_reg) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg <= I_AWADDR;
			end else if (wr_go) begin
				aw_hold_reg <= 1'b0;
			end
			if (I_WVALID && !w_hold_reg) begin
				w_hold_reg <= 1'b1;
				wdata_reg <= I_WDATA;
				wstrb_reg <= I_WSTRB[0];
			end else if (wr_go) begin
				w_hold_reg <= 1'b0;
			end
			if (wr_go) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= w_mapped ? tw_pkg::TW_RESP_OKAY : tw_pkg::TW_RESP_SLVERR;
			end else if (I_BREADY) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// read channel: data registered on the same edge that takes the address
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= tw_pkg::TW_RESP_OKAY;
		end else if (I_CLK_EN) begin
			if (I_ARVALID && !rvalid_reg) begin
				rvalid_reg <= 1'b1;
				rdata_reg <= rd_word;
				rresp_reg <= rd_mapped ? tw_pkg::TW_RESP_OKAY : tw_pkg::TW_RESP_SLVERR;
			end else if (I_RREADY) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RESET_N);

	property p_enable_freeze;
		!I_CLK_EN |=> $stable(cnt_reg) && $stable(wave_a_reg) && $stable(flags_reg);
	endproperty
	a_enable_freeze: assert property (p_enable_freeze) else $error("state moved while disabled"); // R01

	property p_pin_takeover;
		(com_a != 2'b00) && (non_pwm || com_a != 2'b01 || mode_high_reg) |->
			O_PIN_A.level == wave_a_reg && O_PIN_A.oe_n == !dir_reg[0];
	endproperty
	a_pin_takeover: assert property (p_pin_takeover) else $error("pin A not driven by wave"); // R02

	property p_pin_released;
		!non_pwm && com_a == 2'b01 && !mode_high_reg |-> O_PIN_A.level == I_PORT_DATA_A;
	endproperty
	a_pin_released: assert property (p_pin_released) else $error("pin A not released to port"); // R04

	property p_nonpwm_toggle;
		mode == tw_pkg::TW_MODE_NORMAL && match_a && com_a == 2'b01 |=> wave_a_reg != $past(wave_a_reg);
	endproperty
	a_nonpwm_toggle: assert property (p_nonpwm_toggle) else $error("toggle on match missed"); // R03

	property p_pc_up_clear;
		is_pc && match_a && dir_up_reg && ocr_a != top && com_a == 2'b10 |=> !wave_a_reg;
	endproperty
	a_pc_up_clear: assert property (p_pc_up_clear) else $error("up-count match did not clear"); // R05

	property p_fast_b_reserved;
		is_fast && com_b == 2'b01 && $stable(ctrl_a_reg) && $stable(mode_high_reg) [*2] |-> $stable(wave_b_reg);
	endproperty
	a_fast_b_reserved: assert property (p_fast_b_reserved) else $error("reserved B code moved output"); // R09

	property p_reserved_zero;
		ctrl_a_reg[3:2] == 2'b00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero"); // R11

	property p_pc_overflow;
		is_pc && tick && at_bottom && !dir_up_reg |=> flags_reg.overflow;
	endproperty
	a_pc_overflow: assert property (p_pc_overflow) else $error("overflow missed at bottom"); // R14

	property p_match_clear;
		mode == tw_pkg::TW_MODE_CLR_MATCH && tick && at_top && !wr_cnt && !block_reg |=>
			cnt_reg == 8'h00 && flags_reg.match_a;
	endproperty
	a_match_clear: assert property (p_match_clear) else $error("counter not cleared on A match"); // R17

	property p_flag_b;
		match_b |=> flags_reg.match_b;
	endproperty
	a_flag_b: assert property (p_flag_b) else $error("B match flag lost"); // R17

	property p_fast_bottom;
		is_fast && wrap && !wr_cnt && com_b == 2'b10 |=> wave_b_reg && cnt_reg == 8'h00;
	endproperty
	a_fast_bottom: assert property (p_fast_bottom) else $error("BOTTOM set not at wrap"); // R18

	property p_pc_hold_top;
		is_pc && tick && at_top && dir_up_reg && !wr_cnt && top != 8'h00 |=>
			!dir_up_reg && cnt_reg == $past(cnt_reg) - 8'h01;
	endproperty
	a_pc_hold_top: assert property (p_pc_hold_top) else $error("top not left after one tick"); // R19
endmodule
`default_nettype wire

//--- src/tw_pkg.sv
// shared constants and types of the 8-bit timer waveform control block
// Behaviour
// R01 - all timer state is synchronous to the system clock, the timer tick only enables it
// R02 - nonzero channel A output mode takes the pin; pin drives only when direction is output
// R03 - non-PWM channel A: 00 off, 01 toggle, 10 clear, 11 set on match
// R04 - fast PWM A: 01 toggles only with mode high bit; 10/11 clear/set, inverse at BOTTOM
// R05 - phase PWM A: 10 clears up-match, sets down-match; 11 opposite; 01 as fast
// R06 - fast PWM: compare equal TOP with upper mode bit ignores match, acts at BOTTOM only
// R07 - phase PWM: compare equal TOP with upper mode bit ignores match, acts at TOP
// R08 - channel B: same pin takeover and non-PWM codes as channel A
// R09 - fast PWM B: 01 reserved; 10 clear on match set at BOTTOM; 11 reverse
// R10 - phase PWM B: 01 reserved; 10 clear up-match set down-match; 11 reverse
// R11 - control register A bits 3:2 cannot be written and read zero
// R12 - mode is high bit from control B plus two low bits of control A
// R13 - modes 0 and 2: TOP FF or compare A, immediate update, overflow at MAX
// R14 - modes 1 and 5: phase PWM, update at TOP, overflow at BOTTOM
// R15 - modes 3 and 7: fast PWM, update at BOTTOM, overflow at MAX or TOP
// R16 - software never selects modes 4 or 6
// R17 - compare A as TOP clears counter on A match; B match flag in all modes
// R18 - fast PWM BOTTOM action takes effect on the tick that wraps TOP to BOTTOM
// R19 - phase PWM counts up to TOP, holds it one tick, then counts down
// R20 - reset clears control register A: outputs disconnected, normal mode
package tw_pkg;
	localparam logic [7:0] TW_OFS_WAVE_CTRL_A = 8'h24;
	localparam logic [7:0] TW_OFS_TIMER_CTRL_B = 8'h28;
	localparam logic [7:0] TW_OFS_COUNTER = 8'h2c;
	localparam logic [7:0] TW_OFS_COMPARE_A = 8'h30;
	localparam logic [7:0] TW_OFS_COMPARE_B = 8'h34;
	localparam logic [7:0] TW_OFS_FLAGS = 8'h38;
	localparam logic [7:0] TW_OFS_PORT_DIR = 8'h3c;
	localparam int TW_BIT_COM_A = 6;
	localparam int TW_BIT_COM_B = 4;
	localparam int TW_BIT_MODE_HIGH = 3;
	localparam logic [7:0] TW_WAVE_CTRL_A_WMASK = 8'hf3;
	localparam logic [7:0] TW_RST_WAVE_CTRL_A = 8'h00;
	localparam logic TW_RST_MODE_HIGH = 1'b0;
	localparam logic [7:0] TW_RST_COUNTER = 8'h00;
	localparam logic [7:0] TW_RST_COMPARE = 8'h00;
	localparam logic [2:0] TW_RST_FLAGS = 3'h0;
	localparam logic [1:0] TW_RST_PORT_DIR = 2'h0;
	localparam logic [7:0] TW_MAX = 8'hff;
	localparam logic [7:0] TW_BOTTOM = 8'h00;
	localparam logic [1:0] TW_RESP_OKAY = 2'h0;
	localparam logic [1:0] TW_RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		TW_MODE_NORMAL = 3'b000,
		TW_MODE_PC_FF = 3'b001,
		TW_MODE_CLR_MATCH = 3'b010,
		TW_MODE_FAST_FF = 3'b011,
		TW_MODE_RSVD4 = 3'b100,
		TW_MODE_PC_CMP = 3'b101,
		TW_MODE_RSVD6 = 3'b110,
		TW_MODE_FAST_CMP = 3'b111
	} tw_mode_t;
	typedef enum logic [1:0] {
		TW_COM_OFF = 2'b00,
		TW_COM_TOGGLE = 2'b01,
		TW_COM_CLEAR = 2'b10,
		TW_COM_SET = 2'b11
	} tw_com_t;
	typedef struct packed {
		logic level;
		logic oe_n;
	} tw_pin_t;
	typedef struct packed {
		logic match_b;
		logic match_a;
		logic overflow;
	} tw_flags_t;
endpackage

//--- tb/tw_testbench.sv
// self-checking bench of the 8-bit timer waveform control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk, rst_n, en, tick, pda, pdb;
	logic [7:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	tw_pkg::tw_pin_t pin_a, pin_b;
	tw_pkg::tw_flags_t flags;
	int num_errors = 0;
	int comparisons = 0;
	// behavioural model state: counter, direction, wave levels, sticky flags
	int cnt, dir, wa, wb, fl, mode, ca, cb, oa, ob, ddr, top, pc, fast, a_on;
	// mode, code a, code b, compare a, compare b; modes 4 and 6 never chosen
	int tbl[14][5] = '{'{0, 1, 2, 'h10, 'h20}, '{2, 1, 3, 'h30, 'h10}, '{0, 3, 1, 'h80, 'h40},
		'{2, 2, 2, 'h40, 'h20}, '{3, 2, 3, 'h40, 'hff}, '{3, 1, 2, 'h20, 'h90}, '{7, 1, 2, 'h50, 'h20},
		'{7, 3, 1, 'h60, 'h30}, '{7, 2, 3, 'h70, 'h70}, '{1, 2, 3, 'h80, 'hff}, '{1, 3, 2, 'h30, 'h90},
		'{5, 1, 2, 'h40, 'h20}, '{5, 3, 1, 'h40, 'h40}, '{5, 2, 3, 'h60, 'h60}};

	tw_timer8 DUT (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_CLK_EN(en), .I_TIMER_TICK(tick),
		.I_PORT_DATA_A(pda), .I_PORT_DATA_B(pdb), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
		.O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready),
		.O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
		.O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
		.O_PIN_A(pin_a), .O_PIN_B(pin_b), .O_FLAGS(flags));

	// 10 mhz system clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic end_of_test;
		if (num_errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input tw_pkg::tw_pin_t got, input logic [1:0] exp);
		chk_bus({30'h0, got}, {30'h0, exp});
	endtask

	task automatic chk_flag(input tw_pkg::tw_flags_t got, input logic [2:0] exp);
		chk_bus({29'h0, got}, {29'h0, exp});
	endtask

	// axi4-lite write; ready is looked at on the falling edge, where it equals its value at the next rise
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, da, dw;
		da = 1'b0;
		dw = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(da && dw)) begin
			@(negedge clk);
			ta = awvalid && (awready === 1'b1);
			tw = wvalid && (wready === 1'b1);
			@(posedge clk);
			if (ta) begin
				awvalid <= 1'b0;
				da = 1'b1;
			end
			if (tw) begin
				wvalid <= 1'b0;
				dw = 1'b1;
			end
		end
		bready <= 1'b1;
		do @(negedge clk); while (bvalid !== 1'b1);
		resp = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask

	task automatic rdr(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(negedge clk); while (arready !== 1'b1);
		@(posedge clk);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(negedge clk); while (rvalid !== 1'b1);
		rd = rdata;
		resp = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask

	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		cnt = 0;
		dir = 1;
		wa = 0;
		wb = 0;
		fl = 0;
	endtask

	// next wave level of one channel at a tick, from the level and count before it
	function automatic int act(int w, int c, int m, int isa, int ocr);
		int sp;
		sp = (c >= 2 && ocr == top);
		if (pc && sp) return (cnt == top && dir == 1) ? (c == 2) : w;
		if (fast && c >= 2 && cnt == top) return c == 2;
		if (m && c >= 2) return pc ? ((c == 2) == (dir == 0)) : (c == 3);
		if (m && c == 1 && (!(pc || fast) || (isa && mode >= 4))) return !w;
		return w;
	endfunction

	// one timer step of the model; matches and flags use the count before the step
	task automatic step;
		int ma, mb;
		ma = (cnt == oa);
		mb = (cnt == ob);
		fl = fl | (ma << 1) | (mb << 2);
		if (pc ? (cnt == 0 && dir == 0) : (cnt == (mode == 7 ? top : 255))) fl = fl | 1;
		wa = act(wa, ca, ma, 1, oa);
		wb = act(wb, cb, mb, 0, ob);
		if (pc) begin
			if (dir == 1 && cnt == top) dir = 0;
			else if (dir == 0 && cnt == 0) dir = 1;
			cnt = (dir == 1) ? cnt + 1 : cnt - 1;
		end else begin
			cnt = ((mode == 2 && ma) || (mode == 7 && cnt == top)) ? 0 : (cnt + 1) % 256;
		end
	endtask

	// random ticks, enable gaps and port data; pins and flags checked every cycle
	task automatic run(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			if (en && tick) step();
			en <= (i == n - 1) || ($urandom % 8 != 0);
			tick <= (i < n - 1) && ($urandom % 4 != 0);
			pda <= $urandom;
			pdb <= $urandom;
			#1;
			chk_pin(pin_a, {a_on ? wa[0] : pda, ~ddr[0]});
			chk_pin(pin_b, {(cb != 0) ? wb[0] : pdb, ~ddr[1]});
			chk_flag(flags, fl[2:0]);
		end
		@(posedge clk);
	endtask

	// compares loaded while still in normal mode, so every buffer holds them at once
	task automatic scen(input int m, input int a, input int b, input int ra, input int rb);
		do_reset();
		rdr(8'h24);
		chk_bus(rd, 32'h0);
		chk_flag(flags, 3'h0);
		ddr = $urandom % 4;
		mode = m;
		ca = a;
		cb = b;
		oa = ra;
		ob = rb;
		top = (m == 2 || m >= 5) ? ra : 255;
		pc = (m == 1 || m == 5);
		fast = (m == 3 || m == 7);
		a_on = (a != 0) && !(a == 1 && (pc || fast) && m < 4);
		wr(8'h30, ra);
		wr(8'h34, rb);
		wr(8'h3c, ddr);
		wr(8'h28, (m >> 2) << 3);
		wr(8'h24, (a << 6) | (b << 4) | (m & 3) | 12);
		rdr(8'h24);
		chk_bus(rd, (a << 6) | (b << 4) | (m & 3));
		rdr(8'h28);
		chk_bus(rd, (m >> 2) << 3);
		cnt = (m == 1 || m == 5) ? 1 : 0;
		wr(8'h2c, cnt);
		run(1500);
		rdr(8'h2c);
		chk_bus(rd, cnt);
		rdr(8'h38);
		chk_bus(rd, fl);
		wr(8'h38, 32'h7);
		rdr(8'h38);
		chk_bus(rd, 32'h0);
	endtask

	initial begin
		rst_n = 1'b0;
		en = 1'b1;
		tick = 1'b0;
		pda = 1'b0;
		pdb = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		wdata = 32'h0;
		wstrb = 4'hf;
		void'($urandom(2139));
		@(posedge clk);
		do_reset();
		wr(8'h40, 32'hff);
		chk_bus(resp, tw_pkg::TW_RESP_SLVERR);
		rdr(8'h25);
		chk_bus(resp, tw_pkg::TW_RESP_SLVERR);
		chk_bus(rd, 32'h0);
		// a write without its low strobe must leave the register alone
		wstrb <= 4'h0;
		wr(8'h30, 32'h55);
		chk_bus(resp, tw_pkg::TW_RESP_OKAY);
		wstrb <= 4'hf;
		rdr(8'h30);
		chk_bus(rd, 32'h0);
		for (int i = 0; i < 14; i++) scen(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3], tbl[i][4]);
		end_of_test();
	end

	// hang guard, about twice the expected run length
	initial begin
		#5000000;
		num_errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
